/* File: include/alu_pkg.sv */
// Purpose: shared constants and types for the file register datapath
// Assumes: 8-bit data, 16-bit pointers, 7-bit file field
// Notes: register map reached over the plain register port
//
// Functional notes
// - 7-bit file field, destination bit picks target
// - increment adds one, updates zero only
// - OR accumulator with file, zero only
// - left shift, bit7 to carry, zero in
// - right shift, bit0 to carry, zero in
// - move copies value, zero flag from it
// - indirect load into accumulator, zero only
// - mode field selects pre/post inc/dec
// - relative form adds signed offset, pointer kept
// - pointer ends old plus/minus one, relative kept
// - indirect ports access pointed location instead
// - pointers 16 bits, wrap modulo range
// - pointer adjust never touches status flags
package alu_pkg;
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int FILE_W = 7;
    localparam int OFF_W = 6;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam int STATUS_W = 2;
    localparam int STATUS_C_BIT = 0;
    localparam int STATUS_Z_BIT = 1;
    localparam logic [BUS_AW-1:0] OFS_ACC = 8'h00;
    localparam logic [BUS_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [BUS_AW-1:0] OFS_PTR0 = 8'h08;
    localparam logic [BUS_AW-1:0] OFS_PTR1 = 8'h0c;
    localparam logic [BUS_AW-1:0] OFS_STATE = 8'h10;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [STATUS_W-1:0] STATUS_RST = 2'h0;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [FILE_W-1:0] INDIRECT_PORT0 = 7'h00;
    localparam logic [FILE_W-1:0] INDIRECT_PORT1 = 7'h01;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        op_increment_file = 3'h0,
        op_or_accumulator_with_file = 3'h1,
        op_shift_left_logical_file = 3'h2,
        op_shift_right_logical_file = 3'h3,
        op_move_file = 3'h4,
        op_indirect_load_to_accumulator = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        mode_pre_inc = 2'h0,
        mode_pre_dec = 2'h1,
        mode_post_inc = 2'h2,
        mode_post_dec = 2'h3
    } pointer_mode_field_t;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_exec = 2'h1,
        st_write = 2'h2
    } state_t;

    typedef struct packed {
        op_t op;
        logic [FILE_W-1:0] file_addr;
        logic dest;
        logic ptr_sel;
        pointer_mode_field_t pointer_mode_field;
        logic relative;
        logic [OFF_W-1:0] offset;
    } instr_t;

    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;
endpackage

/* File: src/alu_unit.sv */
// Purpose: result and flag logic for the file register operations
// Assumes: operands stable during the execute cycle
// Notes: purely combinational
`timescale 1ns/100ps
module alu_unit (
    // operands
    input wire alu_pkg::op_t op_i,
    input wire logic [alu_pkg::DATA_W-1:0] file_i,
    input wire logic [alu_pkg::DATA_W-1:0] acc_i,
    input wire logic carry_i,
    // results
    output logic [alu_pkg::DATA_W-1:0] result_o,
    output logic carry_o,
    output logic zero_o
);
    always_comb begin
        result_o = file_i;
        carry_o = carry_i;
        case (op_i)
            alu_pkg::op_increment_file: begin
                result_o = file_i + alu_pkg::DATA_ONE;
            end
            alu_pkg::op_or_accumulator_with_file: begin
                result_o = acc_i | file_i;
            end
            alu_pkg::op_shift_left_logical_file: begin
                result_o = {file_i[alu_pkg::DATA_W-2:0], 1'b0};
                carry_o = file_i[alu_pkg::DATA_W-1];
            end
            alu_pkg::op_shift_right_logical_file: begin
                result_o = {1'b0, file_i[alu_pkg::DATA_W-1:1]};
                carry_o = file_i[0];
            end
            alu_pkg::op_move_file: begin
                result_o = file_i;
            end
            alu_pkg::op_indirect_load_to_accumulator: begin
                result_o = file_i;
            end
            default: begin
                result_o = file_i;
            end
        endcase
        zero_o = (result_o == alu_pkg::DATA_ZERO);
    end
endmodule // alu_unit

/* File: src/pointer_unit.sv */
// Purpose: effective address and pointer update for indirect access
// Assumes: offset is two's complement
// Notes: purely combinational, no flags
`timescale 1ns/100ps
module pointer_unit #(
    parameter int PTR_W = alu_pkg::PTR_W,
    parameter int OFF_W = alu_pkg::OFF_W
) (
    // pointer and mode
    input wire logic [PTR_W-1:0] ptr_i,
    input wire alu_pkg::pointer_mode_field_t mode_i,
    input wire logic relative_i,
    input wire logic [OFF_W-1:0] offset_i,
    // results
    output logic [PTR_W-1:0] addr_o,
    output logic [PTR_W-1:0] ptr_next_o
);
    if (OFF_W >= PTR_W || OFF_W < 1) begin : g_bad_width
        $error("pointer_unit: offset width unusable");
    end

    logic [PTR_W-1:0] one_w;
    logic [PTR_W-1:0] inc_w;
    logic [PTR_W-1:0] dec_w;
    logic [PTR_W-1:0] off_w;

    assign one_w = {{(PTR_W-1){1'b0}}, 1'b1};
    assign inc_w = ptr_i + one_w;
    assign dec_w = ptr_i - one_w;
    assign off_w = {{(PTR_W-OFF_W){offset_i[OFF_W-1]}}, offset_i};

    always_comb begin
        addr_o = ptr_i;
        ptr_next_o = ptr_i;
        if (relative_i) begin
            addr_o = ptr_i + off_w;
            ptr_next_o = ptr_i;
        end else begin
            case (mode_i)
                alu_pkg::mode_pre_inc: begin
                    addr_o = inc_w;
                    ptr_next_o = inc_w;
                end
                alu_pkg::mode_pre_dec: begin
                    addr_o = dec_w;
                    ptr_next_o = dec_w;
                end
                alu_pkg::mode_post_inc: begin
                    ptr_next_o = inc_w;
                end
                alu_pkg::mode_post_dec: begin
                    ptr_next_o = dec_w;
                end
                default: begin
                    ptr_next_o = ptr_i;
                end
            endcase
        end
    end
endmodule // pointer_unit

/* File: src/alu_datapath_top.sv */
// Purpose: file register datapath with indirect load
// Assumes: memory answers a read in the same clock as the request
// Notes: an instruction cycle is two clocks, three with file write
`timescale 1ns/100ps
module alu_datapath_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // instruction port
    input wire logic instr_valid_i,
    input wire alu_pkg::instr_t instr_i,
    output logic busy_o,
    output logic done_o,
    // register port
    input wire logic [alu_pkg::BUS_AW-1:0] addr_i,
    input wire logic [alu_pkg::BUS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [alu_pkg::BUS_DW-1:0] rdata_o,
    // data memory
    output alu_pkg::mem_req_t mem_req_o,
    input wire logic [alu_pkg::DATA_W-1:0] mem_rdata_i
);
    ////////////////////////////////////////////////////////////////////////
    // state
    alu_pkg::state_t state_reg, state_next;
    alu_pkg::instr_t instr_reg, instr_next;
    alu_pkg::mem_req_t mem_reg, mem_next;
    logic [alu_pkg::DATA_W-1:0] acc_reg, acc_next;
    logic [alu_pkg::STATUS_W-1:0] status_reg, status_next;
    logic [alu_pkg::PTR_W-1:0] ptr0_reg, ptr0_next;
    logic [alu_pkg::PTR_W-1:0] ptr1_reg, ptr1_next;
    logic [alu_pkg::PTR_W-1:0] pend_reg, pend_next;
    logic pend_sel_reg, pend_sel_next;
    logic pend_en_reg, pend_en_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [alu_pkg::BUS_DW-1:0] rdata_reg, rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // operand selection
    logic is_load;
    logic is_port;
    logic use_ptr;
    logic sel_w;
    logic [alu_pkg::PTR_W-1:0] sel_ptr;
    logic [alu_pkg::PTR_W-1:0] pu_addr;
    logic [alu_pkg::PTR_W-1:0] pu_next;
    logic [alu_pkg::PTR_W-1:0] direct_addr;
    logic [alu_pkg::DATA_W-1:0] alu_result;
    logic alu_carry;
    logic alu_zero;

    assign is_load = (instr_i.op == alu_pkg::op_indirect_load_to_accumulator);
    assign is_port = (instr_i.file_addr == alu_pkg::INDIRECT_PORT0) ||
                     (instr_i.file_addr == alu_pkg::INDIRECT_PORT1);
    assign use_ptr = is_load || is_port;
    assign sel_w = is_load ? instr_i.ptr_sel : instr_i.file_addr[0];
    assign sel_ptr = sel_w ? ptr1_reg : ptr0_reg;
    assign direct_addr = {{(alu_pkg::PTR_W-alu_pkg::FILE_W){1'b0}}, instr_i.file_addr};

    pointer_unit #(
        .PTR_W(alu_pkg::PTR_W),
        .OFF_W(alu_pkg::OFF_W)
    ) u_ptr (
        .ptr_i(sel_ptr),
        .mode_i(instr_i.pointer_mode_field),
        .relative_i(instr_i.relative || !is_load),
        .offset_i(is_load ? instr_i.offset : {alu_pkg::OFF_W{1'b0}}),
        .addr_o(pu_addr),
        .ptr_next_o(pu_next)
    );

    alu_unit u_alu (
        .op_i(instr_reg.op),
        .file_i(mem_rdata_i),
        .acc_i(acc_reg),
        .carry_i(status_reg[alu_pkg::STATUS_C_BIT]),
        .result_o(alu_result),
        .carry_o(alu_carry),
        .zero_o(alu_zero)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        instr_next = instr_reg;
        mem_next = mem_reg;
        mem_next.rd = 1'b0;
        mem_next.wr = 1'b0;
        acc_next = acc_reg;
        status_next = status_reg;
        ptr0_next = ptr0_reg;
        ptr1_next = ptr1_reg;
        pend_next = pend_reg;
        pend_sel_next = pend_sel_reg;
        pend_en_next = pend_en_reg;
        done_next = 1'b0;
        rdata_next = {alu_pkg::BUS_DW{1'b0}};
        if (wr_i) begin
            case (addr_i)
                alu_pkg::OFS_ACC: acc_next = wdata_i[alu_pkg::DATA_W-1:0];
                alu_pkg::OFS_STATUS: status_next = wdata_i[alu_pkg::STATUS_W-1:0];
                alu_pkg::OFS_PTR0: ptr0_next = wdata_i[alu_pkg::PTR_W-1:0];
                alu_pkg::OFS_PTR1: ptr1_next = wdata_i[alu_pkg::PTR_W-1:0];
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                alu_pkg::OFS_ACC: rdata_next = {{(alu_pkg::BUS_DW-alu_pkg::DATA_W){1'b0}}, acc_reg};
                alu_pkg::OFS_STATUS: rdata_next = {{(alu_pkg::BUS_DW-alu_pkg::STATUS_W){1'b0}}, status_reg};
                alu_pkg::OFS_PTR0: rdata_next = {{(alu_pkg::BUS_DW-alu_pkg::PTR_W){1'b0}}, ptr0_reg};
                alu_pkg::OFS_PTR1: rdata_next = {{(alu_pkg::BUS_DW-alu_pkg::PTR_W){1'b0}}, ptr1_reg};
                alu_pkg::OFS_STATE: rdata_next = {{(alu_pkg::BUS_DW-3){1'b0}}, busy_reg, state_reg};
                default: rdata_next = {alu_pkg::BUS_DW{1'b0}};
            endcase
        end
        case (state_reg)
            alu_pkg::st_idle: begin
                if (instr_valid_i) begin
                    instr_next = instr_i;
                    mem_next.addr = use_ptr ? pu_addr : direct_addr;
                    mem_next.rd = 1'b1;
                    pend_next = pu_next;
                    pend_sel_next = sel_w;
                    pend_en_next = is_load;
                    state_next = alu_pkg::st_exec;
                end
            end
            alu_pkg::st_exec: begin
                status_next[alu_pkg::STATUS_Z_BIT] = alu_zero;
                if (instr_reg.op == alu_pkg::op_shift_left_logical_file ||
                    instr_reg.op == alu_pkg::op_shift_right_logical_file) begin
                    status_next[alu_pkg::STATUS_C_BIT] = alu_carry;
                end
                if (pend_en_reg) begin
                    if (pend_sel_reg) begin
                        ptr1_next = pend_reg;
                    end else begin
                        ptr0_next = pend_reg;
                    end
                end
                if (instr_reg.dest == alu_pkg::DEST_FILE && !pend_en_reg) begin
                    mem_next.wr = 1'b1;
                    mem_next.wdata = alu_result;
                    state_next = alu_pkg::st_write;
                end else begin
                    acc_next = alu_result;
                    done_next = 1'b1;
                    state_next = alu_pkg::st_idle;
                end
            end
            alu_pkg::st_write: begin
                done_next = 1'b1;
                state_next = alu_pkg::st_idle;
            end
            default: begin
                state_next = alu_pkg::st_idle;
            end
        endcase
        busy_next = (state_next != alu_pkg::st_idle);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= alu_pkg::st_idle;
            instr_reg <= '0;
            mem_reg <= '0;
            acc_reg <= alu_pkg::ACC_RST;
            status_reg <= alu_pkg::STATUS_RST;
            ptr0_reg <= alu_pkg::PTR_RST;
            ptr1_reg <= alu_pkg::PTR_RST;
            pend_reg <= alu_pkg::PTR_RST;
            pend_sel_reg <= 1'b0;
            pend_en_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            mem_reg <= mem_next;
            acc_reg <= acc_next;
            status_reg <= status_next;
            ptr0_reg <= ptr0_next;
            ptr1_reg <= ptr1_next;
            pend_reg <= pend_next;
            pend_sel_reg <= pend_sel_next;
            pend_en_reg <= pend_en_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign rdata_o = rdata_reg;
    assign mem_req_o = mem_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic ex;
    logic take;
    assign ex = ce_i && (state_reg == alu_pkg::st_exec);
    assign take = ce_i && (state_reg == alu_pkg::st_idle) && instr_valid_i;

    property p_increment;
        ex && instr_reg.op == alu_pkg::op_increment_file && instr_reg.dest == alu_pkg::DEST_ACC
        |=> acc_reg == $past(mem_rdata_i) + alu_pkg::DATA_ONE;
    endproperty
    a_increment: assert property (p_increment) else $error("increment result wrong");

    property p_or_file;
        ex && instr_reg.op == alu_pkg::op_or_accumulator_with_file && instr_reg.dest == alu_pkg::DEST_ACC
        |=> acc_reg == ($past(mem_rdata_i) | $past(acc_reg));
    endproperty
    a_or_file: assert property (p_or_file) else $error("or result wrong");

    property p_shift_left;
        ex && instr_reg.op == alu_pkg::op_shift_left_logical_file && instr_reg.dest == alu_pkg::DEST_ACC
        |=> acc_reg == {$past(mem_rdata_i[6:0]), 1'b0} && status_reg[0] == $past(mem_rdata_i[7]);
    endproperty
    a_shift_left: assert property (p_shift_left) else $error("left shift wrong");

    property p_shift_right;
        ex && instr_reg.op == alu_pkg::op_shift_right_logical_file && instr_reg.dest == alu_pkg::DEST_ACC
        |=> acc_reg == {1'b0, $past(mem_rdata_i[7:1])} && status_reg[0] == $past(mem_rdata_i[0]);
    endproperty
    a_shift_right: assert property (p_shift_right) else $error("right shift wrong");

    property p_move_zero;
        ex && instr_reg.op == alu_pkg::op_move_file
        |=> status_reg[1] == ($past(mem_rdata_i) == alu_pkg::DATA_ZERO);
    endproperty
    a_move_zero: assert property (p_move_zero) else $error("zero flag wrong");

    property p_load;
        ex && pend_en_reg |=> acc_reg == $past(mem_rdata_i) && status_reg[1] == (acc_reg == 8'h00);
    endproperty
    a_load: assert property (p_load) else $error("indirect load wrong");

    property p_file_write;
        ex && instr_reg.dest == alu_pkg::DEST_FILE && !pend_en_reg
        |=> mem_req_o.wr && mem_req_o.addr == $past(mem_req_o.addr) && !done_o
        ##1 ($past(ce_i) ? (done_o && !mem_req_o.wr) : mem_req_o.wr);
    endproperty
    a_file_write: assert property (p_file_write) else $error("file write wrong");

    property p_carry_kept;
        ex && !wr_i && instr_reg.op != alu_pkg::op_shift_left_logical_file &&
        instr_reg.op != alu_pkg::op_shift_right_logical_file |=> $stable(status_reg[0]);
    endproperty
    a_carry_kept: assert property (p_carry_kept) else $error("carry disturbed");

    property p_pre_dec;
        take && is_load && !instr_i.relative && instr_i.ptr_sel &&
        instr_i.pointer_mode_field == alu_pkg::mode_pre_dec |=> mem_req_o.addr == $past(ptr1_reg) - 16'h0001;
    endproperty
    a_pre_dec: assert property (p_pre_dec) else $error("pre decrement address wrong");

    property p_wrap;
        take && is_load && !instr_i.relative && !instr_i.ptr_sel && ptr0_reg == 16'hffff &&
        instr_i.pointer_mode_field == alu_pkg::mode_pre_inc |=> mem_req_o.addr == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer wrap wrong");

    property p_post_inc;
        (take && is_load && !instr_i.relative && !instr_i.ptr_sel && !wr_i &&
         instr_i.pointer_mode_field == alu_pkg::mode_post_inc) ##1 (ce_i && !wr_i)
        |=> ptr0_reg == $past(ptr0_reg, 2) + 16'h0001 && mem_req_o.addr == $past(ptr0_reg, 2);
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

    property p_relative;
        (take && is_load && instr_i.relative && !instr_i.ptr_sel && !wr_i) ##1 (ce_i && !wr_i)
        |=> $stable(ptr0_reg) &&
            mem_req_o.addr == $past(ptr0_reg, 2) + {{10{$past(instr_i.offset[5], 2)}}, $past(instr_i.offset, 2)};
    endproperty
    a_relative: assert property (p_relative) else $error("relative access wrong");

    property p_port;
        take && !is_load && instr_i.file_addr == alu_pkg::INDIRECT_PORT1 |=> mem_req_o.addr == $past(ptr1_reg);
    endproperty
    a_port: assert property (p_port) else $error("indirect port address wrong");

    property p_one_cycle;
        ex && (instr_reg.dest == alu_pkg::DEST_ACC || pend_en_reg) |=> done_o && !busy_o;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("instruction not finished");

    c_post_inc: cover property (take && is_load && instr_i.pointer_mode_field == alu_pkg::mode_post_inc);
    c_file_write: cover property (mem_req_o.wr ##1 done_o);
    c_relative: cover property (take && is_load && instr_i.relative);
    c_wrap: cover property (ex && pend_en_reg && ptr0_reg == 16'hffff);
    c_port: cover property (take && !is_load && is_port);
endmodule // alu_datapath_top

/* File: verification/data_memory_model.sv */
// Purpose: data memory and special register space behind the datapath
// Assumes: read data must stand in the same clock as the read request
// Notes: when no read is in progress, the bus shows the inverse of the last read
`timescale 1ns/100ps
module data_memory_model (
    // clock
    input wire logic clock_i,
    // request
    input wire alu_pkg::mem_req_t mem_req_i,
    // answer
    output logic [alu_pkg::DATA_W-1:0] mem_rdata_o
);
    logic [alu_pkg::DATA_W-1:0] mem [0:65535];
    logic [alu_pkg::DATA_W-1:0] last_reg = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // the full 16-bit address selects the cell
    always @(posedge clock_i) begin
        if (mem_req_i.wr) begin
            mem[mem_req_i.addr] <= mem_req_i.wdata;
        end
        if (mem_req_i.rd) begin
            last_reg <= mem[mem_req_i.addr];
        end
    end
    assign mem_rdata_o = mem_req_i.rd ? mem[mem_req_i.addr] : ~last_reg;
endmodule // data_memory_model

/* File: verification/testbench.sv */
// Purpose: self-checking bench for the file register datapath
// Assumes: register port and instruction timing as handed over
// Notes: memory cells are preset straight into the memory model
`timescale 1ns/100ps
module testbench;
    logic clock_i, rst_n_i, ce_i, instr_valid_i, wr_i, rd_i, busy_o, done_o;
    alu_pkg::instr_t instr_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o;
    alu_pkg::mem_req_t mem_req;
    logic [7:0] mem_rdata;
    int n_errors = 0;
    int total_checks = 0;
    logic [7:0] fv [5] = '{8'hff, 8'h3c, 8'h81, 8'h01, 8'h00};
    logic [7:0] av [5] = '{8'h12, 8'hc0, 8'h77, 8'h55, 8'h9a};
    logic [1:0] sv [5] = '{2'h1, 2'h2, 2'h2, 2'h0, 2'h1};
    logic [15:0] p0, np, ea;
    logic [8:0] e;
    logic [7:0] lv;
    logic [6:0] fa;
    ////////////////////////////////////////////////////////////////////////////
    alu_datapath_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .mem_req_o(mem_req), .mem_rdata_i(mem_rdata));
    data_memory_model mem_u (.clock_i(clock_i), .mem_req_i(mem_req), .mem_rdata_o(mem_rdata));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 check(nm, rdata_o, exp);
    endtask
    task automatic run(input int op, input logic [6:0] f, input logic d, input logic ps, input logic [1:0] md,
        input logic rel, input logic [5:0] off);
        int n;
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        instr_i <= '{op: alu_pkg::op_t'(op[2:0]), file_addr: f, dest: d, ptr_sel: ps,
            pointer_mode_field: alu_pkg::pointer_mode_field_t'(md), relative: rel, offset: off};
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        #1 check("busy", busy_o, 1'b1);
        n = 1;
        do begin
            @(posedge clock_i);
            #1 n++;
        end while (done_o !== 1'b1 && n < 8);
        if (n >= 8) begin
            n_errors++;
            end_of_test();
        end
        check("cycles", n, (d && op != 5) ? 3 : 2);
        check("idle", busy_o, 1'b0);
    endtask
    function automatic logic [8:0] exp_alu(input int k, input logic [7:0] f, input logic [7:0] a, input logic c);
        case (k)
            0: return {c, f + 8'h01};
            1: return {c, f | a};
            2: return {f[7], f[6:0], 1'b0};
            3: return {f[0], 1'b0, f[7:1]};
            default: return {c, f};
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        instr_valid_i = 1'b0;
        instr_i = '0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        reg_rd("acc", alu_pkg::OFS_ACC, 32'h0000_0000);
        reg_rd("status", alu_pkg::OFS_STATUS, 32'h0000_0000);
        reg_rd("ptr1", alu_pkg::OFS_PTR1, 32'h0000_0000);
        reg_wr(8'h20, 32'h0000_00ff);
        reg_rd("unmapped", 8'h20, 32'h0000_0000);
        ce_i <= 1'b0;
        reg_wr(alu_pkg::OFS_ACC, 32'h0000_00a5);
        ce_i <= 1'b1;
        reg_rd("frozen", alu_pkg::OFS_ACC, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            for (int d = 0; d < 2; d++) begin
                fa = i[0] ? 7'h7f : 7'h40;
                mem_u.mem[{9'h000, fa}] = fv[i];
                reg_wr(alu_pkg::OFS_ACC, {24'h00_0000, av[i]});
                reg_wr(alu_pkg::OFS_STATUS, {30'h0000_0000, sv[i]});
                e = exp_alu(i, fv[i], av[i], sv[i][0]);
                run(i, fa, d[0], 1'b0, 2'h0, 1'b0, 6'h00);
                reg_rd("acc", alu_pkg::OFS_ACC, {24'h00_0000, d[0] ? av[i] : e[7:0]});
                reg_rd("status", alu_pkg::OFS_STATUS, {30'h0000_0000, e[7:0] == 8'h00, e[8]});
                check("file", mem_u.mem[{9'h000, fa}], d[0] ? e[7:0] : fv[i]);
            end
        end
        reg_wr(alu_pkg::OFS_PTR1, 32'h0000_1234);
        mem_u.mem[16'h1234] = 8'h5a;
        run(4, 7'h01, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
        reg_rd("acc", alu_pkg::OFS_ACC, 32'h0000_005a);
        reg_rd("ptr1", alu_pkg::OFS_PTR1, 32'h0000_1234);
        reg_wr(alu_pkg::OFS_PTR0, 32'h0000_beef);
        mem_u.mem[16'hbeef] = 8'h10;
        run(0, 7'h00, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
        check("port0", mem_u.mem[16'hbeef], 32'h0000_0011);
        for (int m = 0; m < 4; m++) begin
            p0 = m[0] ? 16'h0000 : 16'hffff;
            np = m[0] ? p0 - 16'h0001 : p0 + 16'h0001;
            ea = m[1] ? p0 : np;
            lv = (m == 2) ? 8'h00 : 8'h80 | m[7:0];
            mem_u.mem[ea] = lv;
            mem_u.mem[m[1] ? np : p0] = ~lv;
            reg_wr(m[0] ? alu_pkg::OFS_PTR1 : alu_pkg::OFS_PTR0, {16'h0000, p0});
            reg_wr(alu_pkg::OFS_STATUS, 32'h0000_0001);
            run(5, 7'h00, 1'b1, m[0], m[1:0], 1'b0, 6'h00);
            reg_rd("acc", alu_pkg::OFS_ACC, {24'h00_0000, lv});
            reg_rd("status", alu_pkg::OFS_STATUS, {30'h0000_0000, lv == 8'h00, 1'b1});
            reg_rd("ptr", m[0] ? alu_pkg::OFS_PTR1 : alu_pkg::OFS_PTR0, {16'h0000, np});
        end
        for (int j = 0; j < 2; j++) begin
            ea = j ? 16'h002f : 16'hfff0;
            mem_u.mem[ea] = 8'h3c + j[7:0];
            reg_wr(alu_pkg::OFS_PTR0, 32'h0000_0010);
            run(5, 7'h00, 1'b0, 1'b0, 2'h2, 1'b1, j ? 6'h1f : 6'h20);
            reg_rd("acc", alu_pkg::OFS_ACC, {24'h00_0000, 8'h3c + j[7:0]});
            reg_rd("ptr0", alu_pkg::OFS_PTR0, 32'h0000_0010);
        end
        reg_rd("state", alu_pkg::OFS_STATE, 32'h0000_0000);
        end_of_test();
    end
endmodule // testbench
